// file: inc/rx_term_pkg.sv
// Shared constants for the receive record terminator block.
// Assumes a single 200 MHz APB clock domain; no other users yet.
package rx_term_pkg;
    // APB register byte offsets
    localparam logic [7:0] CFG_OFF = 8'h00;
    localparam logic [7:0] EOC_OFF = 8'h04;
    localparam logic [7:0] TERM0_OFF = 8'h08;
    localparam logic [7:0] TERM1_OFF = 8'h0C;
    localparam logic [7:0] ECHOSEL_OFF = 8'h10;
    localparam logic [7:0] CMD_OFF = 8'h14;
    localparam logic [7:0] STAT_OFF = 8'h18;
    localparam logic [7:0] REC_OFF = 8'h1C;
    localparam logic [7:0] EVT_OFF = 8'h20;
    // Configuration bit positions
    localparam int CFG_TERM_EN = 0;
    localparam int CFG_STORE_TERM = 1;
    localparam int CFG_EOC_EN = 2;
    localparam int CFG_ALERT = 3;
    localparam int CFG_ECHO = 4;
    localparam int CFG_FULL_DUPLEX = 5;
    localparam int CFG_CRLF = 6;
    localparam int CFG_NO_ERR_TERM = 7;
    // Command bit positions
    localparam int CMD_READ = 0;
    localparam int CMD_TGL_TERM = 1;
    localparam int CMD_TGL_ECHO = 2;
    localparam int CMD_SAVE = 3;
    localparam int CMD_HOST_TERM = 4;
    localparam int CMD_LEN_LSB = 8;
    // Reset values and internal counts
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] EOC_RST = 8'h00;
    localparam logic [7:0] CR_CHAR = 8'h0D;
    localparam logic [7:0] LF_CHAR = 8'h0A;
    localparam logic [8:0] CARD_EOC = 9'h0FC;
    localparam logic [8:0] ECHO_DEPTH = 9'h080;
    localparam logic [4:0] SUBF_HOST_TERM = 5'h04;
    // Termination codes
    typedef enum logic [2:0] {
        TC_NONE = 3'b000,
        TC_TERM_CHAR = 3'b001,
        TC_EOC = 3'b010,
        TC_CARD_MORE = 3'b011,
        TC_CARD_DONE = 3'b100,
        TC_ALERT = 3'b101,
        TC_HOST = 3'b110,
        TC_ERROR = 3'b111
    } term_code_e;
endpackage

// file: sim/rx_record_terminator_tb.sv
// Bench for the receive record terminator: APB tasks and scenarios.
// Assumes rx_term_pkg and the terminal model rx_term_partner.
`timescale 1ns/1ps
module rx_record_terminator_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic pready, pslverr, e;
    logic rx_valid, rx_error, tx_record_active, echo_pop, echo_valid;
    logic [7:0] rx_char, echo_char;
    logic data_avail_evt, read_done, done_seen, evt_seen;
    logic [2:0] read_code, got_code;
    logic [8:0] read_len, got_len;
    int bad_count = 0;
    int n_checks = 0;
    // Clock at 200 MHz
    initial forever #2.5 pclk = ~pclk;
    rx_record_terminator #(.BUF_DEPTH(512)) i_rx_record_terminator (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_char(rx_char), .rx_error(rx_error),
        .tx_record_active(tx_record_active), .echo_pop(echo_pop),
        .echo_char(echo_char), .echo_valid(echo_valid),
        .data_avail_evt(data_avail_evt), .read_done(read_done),
        .read_code(read_code), .read_len(read_len));
    rx_term_partner i_rx_term_partner (
        .pclk(pclk), .rx_valid(rx_valid), .rx_char(rx_char),
        .rx_error(rx_error), .tx_record_active(tx_record_active),
        .echo_pop(echo_pop), .echo_valid(echo_valid),
        .echo_char(echo_char));
    // Latch one-cycle completion and alert pulses
    always @(posedge pclk) begin
        if (read_done === 1'b1) begin
            done_seen = 1'b1;
            got_code = read_code;
            got_len = read_len;
        end
        if (data_avail_evt === 1'b1) begin
            evt_seen = 1'b1;
        end
    end
    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            print_verdict();
        end
    endtask
    // Command word: length in [16:8], flags below
    task automatic cmd(input logic [8:0] len, input logic [7:0] f);
        done_seen = 1'b0;
        apb(1'b1, rx_term_pkg::CMD_OFF, {15'h0000, len, f});
    endtask
    // Wait for a read completion, then compare code and length
    task automatic chk_read(input logic [2:0] c, input logic [8:0] len);
        for (int n = 0; n < 400 && done_seen !== 1'b1; n++) @(posedge pclk);
        if (done_seen !== 1'b1) begin
            bad_count++;
            print_verdict();
        end
        check({29'h0, got_code}, {29'h0, c});
        check({23'h0, got_len}, {23'h0, len});
    endtask
    task automatic str(input string s);
        foreach (s[i]) i_rx_term_partner.send(s[i], 1'b0);
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, rx_term_pkg::CFG_OFF, 32'h0);
        check(q, 32'h0000_0000);
        apb(1'b0, 8'h24, 32'h0);
        check({31'h0, e}, 32'h0000_0001);
        apb(1'b1, rx_term_pkg::TERM0_OFF, 32'h0D0D_0D0D);
        apb(1'b1, rx_term_pkg::TERM1_OFF, 32'h7E0D_0D0D);
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0001);
        str("A~");
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_TERM_CHAR, 9'h001);
        apb(1'b0, rx_term_pkg::STAT_OFF, 32'h0);
        check({16'h0, q[15:0]}, 32'h0000_7E01);
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0003);
        str("C\r");
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_TERM_CHAR, 9'h002);
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0000);
        cmd(9'h12C, 8'h03);
        str("Q\r");
        chk_read(rx_term_pkg::TC_TERM_CHAR, 9'h001);
        cmd(9'h004, 8'h01);
        apb(1'b0, rx_term_pkg::STAT_OFF, 32'h0);
        check({31'h0, q[16]}, 32'h0000_0001);
        str("wxyz");
        chk_read(rx_term_pkg::TC_CARD_DONE, 9'h004);
        apb(1'b1, rx_term_pkg::EOC_OFF, 32'h0000_0003);
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0004);
        str("abc");
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_EOC, 9'h003);
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0000);
        for (int i = 0; i < 252; i++) i_rx_term_partner.send(8'h41, 1'b0);
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_CARD_MORE, 9'h0FC);
        str("abcdef");
        cmd(9'h004, 8'h01);
        chk_read(rx_term_pkg::TC_CARD_DONE, 9'h004);
        str("ab");
        i_rx_term_partner.send(8'h63, 1'b1);
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_ERROR, 9'h003);
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0080);
        i_rx_term_partner.send(8'h64, 1'b1);
        cmd(9'h000, 8'h10);
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_HOST, 9'h001);
        cmd(9'h000, 8'h10);
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_HOST, 9'h000);
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0008);
        evt_seen = 1'b0;
        str("Z");
        repeat (6) @(posedge pclk);
        check({31'h0, evt_seen}, 32'h0000_0001);
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_ALERT, 9'h001);
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_ALERT, 9'h000);
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0009);
        str("K\r");
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_TERM_CHAR, 9'h001);
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0001);
        str("P");
        apb(1'b1, rx_term_pkg::CFG_OFF, 32'h0000_0031);
        str("\r");
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_TERM_CHAR, 9'h001);
        i_rx_term_partner.slow = 1'b1;
        i_rx_term_partner.tx_record_active <= 1'b1;
        str("E");
        repeat (8) @(posedge pclk);
        check(32'(i_rx_term_partner.echoed.size()), 32'h0);
        i_rx_term_partner.tx_record_active <= 1'b0;
        repeat (10) @(posedge pclk);
        check(32'(i_rx_term_partner.echoed.size()), 32'h1);
        check({24'h0, i_rx_term_partner.echoed[0]}, 32'h45);
        str("\r");
        repeat (10) @(posedge pclk);
        check(32'(i_rx_term_partner.echoed.size()), 32'h1);
        cmd(9'h12C, 8'h01);
        chk_read(rx_term_pkg::TC_TERM_CHAR, 9'h001);
        print_verdict();
    end
endmodule

// file: sim/rx_term_partner.sv
// Terminal-side model: sends received characters, consumes echoes.
// Assumes one pclk domain; the bench calls send and sets slow.
`timescale 1ns/1ps
module rx_term_partner (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_char,
    output logic rx_error,
    output logic tx_record_active,
    output logic echo_pop,
    input wire logic echo_valid,
    input wire logic [7:0] echo_char
);
    logic slow = 1'b0; // Consumer takes only every other cycle
    logic ph = 1'b0; // Phase for the slow consumer
    logic [7:0] echoed [$]; // Echo characters taken so far
    // Idle values at time zero
    initial begin
        rx_valid = 1'b0;
        rx_char = 8'h00;
        rx_error = 1'b0;
        tx_record_active = 1'b0;
        echo_pop = 1'b0;
    end
    // One character strobe; the data line is inverted once idle
    task automatic send(input logic [7:0] c, input logic e);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_char <= c;
        rx_error <= e;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_char <= ~c;
        rx_error <= 1'b0;
    endtask
    // Echo consumer, prompt or slow; never pops twice in a row
    always @(posedge pclk) begin
        ph <= ~ph;
        if (echo_pop && echo_valid) begin
            echoed.push_back(echo_char);
        end
        echo_pop <= echo_valid && !echo_pop && !(slow && ph);
    end
endmodule

// file: verilog/rx_record_terminator.sv
// Receive record manager for one serial port: termination, echo, reads.
// Assumes characters arrive as one-cycle strobes synchronous to pclk and
// that the transmit side pops echoes with echo_pop when it can send.
//
// How it works
// - Terminator dropped unless store option; reported
// - Eight programmable terminator characters end record
// - Terminator enable from config, toggled per read
// - User count decrements, zero ends record
// - Card ends record at 252 bytes
// - Alert mode raises data-available on first char
// - Alert read returns everything received so far
// - Enabled termination beats alert code
// - Alert read with no data: zero length
// - Alert read forces active record with alert
// - Alert event only for a new record, not for parked data
// - Full buffer drops and does not echo
// - New parameters apply after active record ends, echo select at once
// - Echo held while transmit record active
// - 128-byte echo buffer, overflow loses echoes
// - Echo by config, toggled, full duplex only
// - Terminators never echoed, optional CR/LF pair
// - Errors end record unless disabled
// - Read ends satisfiable record, no-more-data code
// - Save flag keeps a parked record's remainder for later reads
// - Shortfall down-counter suspends read until zero
// - Host terminate ends record, maybe empty
`timescale 1ns/1ps
module rx_record_terminator #(
    parameter int BUF_DEPTH = 1024
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_error,
    input wire logic tx_record_active,
    input wire logic echo_pop,
    output logic [7:0] echo_char,
    output logic echo_valid,
    output logic data_avail_evt,
    output logic read_done,
    output logic [2:0] read_code,
    output logic [8:0] read_len
);
    localparam int AW = $clog2(BUF_DEPTH);
    // Buffer storage and write pointer; count of stored bytes
    logic [7:0] buf_mem [BUF_DEPTH];
    logic [AW:0] buf_cnt_r;
    logic [AW-1:0] wr_ptr_r;
    // Echo buffer
    logic [7:0] echo_mem [128];
    logic [6:0] echo_wp_r, echo_rp_r;
    logic [8:0] echo_cnt_r;
    // Live and staged configuration
    logic [7:0] cfg_r, cfg_stage_r, eoc_r, eoc_stage_r;
    logic [63:0] term_r, term_stage_r;
    logic [7:0] echo_sel_r;
    logic stage_pend_r;
    // Active front record state
    logic [8:0] rec_len_r;
    logic [7:0] eoc_cnt_r;
    logic [7:0] last_term_r;
    logic [2:0] last_code_r;
    logic [8:0] done_len_r;
    // Pending read state
    logic rd_pend_r, bp_valid_r, tgl_term_r, tgl_echo_r;
    logic [8:0] rd_down_r, bp_len_r;
    logic alert_sent_r;
    logic [2:0] bp_code_r; // Code of the record parked for the host
    logic [7:0] stat_evt_r;

    // Match received byte against the eight terminator slots
    function automatic logic term_match(input logic [63:0] t,
                                        input logic [7:0] c);
        logic m;
        m = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (t[i*8 +: 8] == c) begin
                m = 1'b1;
            end
        end
        return m;
    endfunction

    // Effective options for the current request
    logic term_on, echo_on, buf_full, is_term, rec_active;
    logic bus_wr, bus_rd;
    assign rec_active = (rec_len_r != 9'h000);
    assign term_on = cfg_r[rx_term_pkg::CFG_TERM_EN] ^ tgl_term_r;
    assign echo_on = (cfg_r[rx_term_pkg::CFG_ECHO] ^ tgl_echo_r)
                   & cfg_r[rx_term_pkg::CFG_FULL_DUPLEX];
    assign buf_full = (buf_cnt_r == (AW+1)'(BUF_DEPTH));
    assign is_term = term_on && term_match(term_r, rx_char);
    assign bus_wr = psel && penable && pwrite;
    assign bus_rd = psel && !penable && !pwrite;

    // Termination decision for the arriving character, fixed order
    logic [2:0] code_nxt;
    logic store_nxt;
    always_comb begin
        code_nxt = rx_term_pkg::TC_NONE;
        store_nxt = 1'b1;
        if (rx_error && !cfg_r[rx_term_pkg::CFG_NO_ERR_TERM]) begin
            code_nxt = rx_term_pkg::TC_ERROR;
        end else if (is_term) begin
            code_nxt = rx_term_pkg::TC_TERM_CHAR;
            store_nxt = cfg_r[rx_term_pkg::CFG_STORE_TERM];
        end else if (cfg_r[rx_term_pkg::CFG_EOC_EN] &&
                     eoc_cnt_r == 8'h01) begin
            code_nxt = rx_term_pkg::TC_EOC;
        end else if (rd_pend_r && rd_down_r == 9'h001) begin
            code_nxt = rx_term_pkg::TC_CARD_DONE;
        end else if (rec_len_r + 9'h001 == rx_term_pkg::CARD_EOC) begin
            code_nxt = rx_term_pkg::TC_CARD_MORE;
        end
    end

    logic accept, ended, host_cmd, read_cmd, force_rd;
    logic [8:0] bp_take;
    assign accept = rx_valid && !buf_full;
    assign ended = accept && code_nxt != rx_term_pkg::TC_NONE;
    assign host_cmd = bus_wr && paddr == rx_term_pkg::CMD_OFF &&
                      pwdata[rx_term_pkg::CMD_HOST_TERM];
    assign read_cmd = bus_wr && paddr == rx_term_pkg::CMD_OFF &&
                      pwdata[rx_term_pkg::CMD_READ];
    // Read that cuts the active record now
    assign force_rd = read_cmd && !rd_pend_r && !bp_valid_r && rec_active &&
        (cfg_r[rx_term_pkg::CFG_ALERT] || rec_len_r >= pwdata[16:8]);
    assign bp_take = (pwdata[16:8] < bp_len_r) ? pwdata[16:8] : bp_len_r;

    // Receive buffer write and record tracking
    always_ff @(posedge pclk) begin
        if (accept && store_nxt) begin
            buf_mem[wr_ptr_r] <= rx_char;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= '0;
            buf_cnt_r <= '0;
            rec_len_r <= 9'h000;
            eoc_cnt_r <= rx_term_pkg::EOC_RST;
            last_code_r <= rx_term_pkg::TC_NONE;
            last_term_r <= 8'h00;
            done_len_r <= 9'h000;
        end else begin
            // Host read consumes a record from the buffer
            if (read_done) begin
                buf_cnt_r <= buf_cnt_r - (AW+1)'(read_len);
            end
            if (accept && store_nxt) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
                buf_cnt_r <= buf_cnt_r + 1'b1 -
                    (read_done ? (AW+1)'(read_len) : '0);
            end
            if (ended) begin
                last_code_r <= code_nxt;
                done_len_r <= rec_len_r + 9'(store_nxt);
                rec_len_r <= 9'h000;
                eoc_cnt_r <= eoc_r;
                if (code_nxt == rx_term_pkg::TC_TERM_CHAR) begin
                    last_term_r <= rx_char;
                end
            end else if (host_cmd && !buf_full) begin
                last_code_r <= rx_term_pkg::TC_HOST;
                done_len_r <= rec_len_r;
                rec_len_r <= 9'h000;
                eoc_cnt_r <= eoc_r;
            end else if (force_rd) begin
                // Read forces out the active record
                last_code_r <= cfg_r[rx_term_pkg::CFG_ALERT] ?
                    rx_term_pkg::TC_ALERT :
                    rx_term_pkg::TC_CARD_DONE;
                done_len_r <= rec_len_r;
                rec_len_r <= 9'h000;
                eoc_cnt_r <= eoc_r;
            end else if (accept) begin
                rec_len_r <= rec_len_r + 1'b1;
                if (cfg_r[rx_term_pkg::CFG_EOC_EN]) begin
                    eoc_cnt_r <= eoc_cnt_r - 8'h01;
                end
            end else if (!rec_active) begin
                eoc_cnt_r <= eoc_r; // Idle: follow live count
            end
        end
    end

    // Staged parameters take effect once no record is active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= rx_term_pkg::CFG_RST;
            cfg_stage_r <= rx_term_pkg::CFG_RST;
            eoc_r <= rx_term_pkg::EOC_RST;
            eoc_stage_r <= rx_term_pkg::EOC_RST;
            term_r <= '0;
            term_stage_r <= '0;
            echo_sel_r <= rx_term_pkg::CR_CHAR;
            stage_pend_r <= 1'b0;
        end else begin
            if (bus_wr && paddr == rx_term_pkg::CFG_OFF) begin
                cfg_stage_r <= pwdata[7:0];
                stage_pend_r <= 1'b1;
            end else if (bus_wr && paddr == rx_term_pkg::EOC_OFF) begin
                eoc_stage_r <= pwdata[7:0];
                stage_pend_r <= 1'b1;
            end else if (bus_wr && paddr == rx_term_pkg::TERM0_OFF) begin
                term_stage_r[31:0] <= pwdata;
                stage_pend_r <= 1'b1;
            end else if (bus_wr && paddr == rx_term_pkg::TERM1_OFF) begin
                term_stage_r[63:32] <= pwdata;
                stage_pend_r <= 1'b1;
            end else if (bus_wr && paddr == rx_term_pkg::ECHOSEL_OFF) begin
                echo_sel_r <= pwdata[7:0];
            end else if (stage_pend_r && !rec_active) begin
                cfg_r <= cfg_stage_r;
                eoc_r <= eoc_stage_r;
                term_r <= term_stage_r;
                stage_pend_r <= 1'b0;
            end
        end
    end

    // Host read handling and completion reporting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pend_r <= 1'b0;
            bp_valid_r <= 1'b0;
            bp_code_r <= rx_term_pkg::TC_NONE;
            tgl_term_r <= 1'b0;
            tgl_echo_r <= 1'b0;
            rd_down_r <= 9'h000;
            bp_len_r <= 9'h000;
            read_done <= 1'b0;
            read_code <= rx_term_pkg::TC_NONE;
            read_len <= 9'h000;
        end else begin
            read_done <= 1'b0;
            if (read_cmd && !rd_pend_r) begin
                if (bp_valid_r) begin
                    // Parked record first; leftover kept if saving
                    read_done <= 1'b1;
                    read_code <= bp_code_r;
                    read_len <= bp_take;
                    bp_len_r <= bp_len_r - bp_take;
                    bp_code_r <= rx_term_pkg::TC_CARD_DONE;
                    bp_valid_r <= pwdata[rx_term_pkg::CMD_SAVE] &&
                                  bp_len_r != bp_take;
                end else if (force_rd) begin
                    read_done <= 1'b1;
                    read_code <= cfg_r[rx_term_pkg::CFG_ALERT] ?
                        rx_term_pkg::TC_ALERT : rx_term_pkg::TC_CARD_DONE;
                    read_len <= cfg_r[rx_term_pkg::CFG_ALERT] ?
                        rec_len_r : pwdata[16:8];
                end else if (cfg_r[rx_term_pkg::CFG_ALERT]) begin
                    read_done <= 1'b1;
                    read_code <= rx_term_pkg::TC_ALERT;
                    read_len <= 9'h000;
                end else begin
                    // Wait for the shortfall; toggles last this read
                    rd_pend_r <= 1'b1;
                    rd_down_r <= pwdata[16:8] - rec_len_r;
                    tgl_term_r <= pwdata[rx_term_pkg::CMD_TGL_TERM];
                    tgl_echo_r <= pwdata[rx_term_pkg::CMD_TGL_ECHO];
                end
            end else if (rd_pend_r && (ended || host_cmd)) begin
                rd_pend_r <= 1'b0;
                read_done <= 1'b1;
                read_code <= ended ? code_nxt : rx_term_pkg::TC_HOST;
                read_len <= ended ? rec_len_r + 9'(store_nxt) : rec_len_r;
                tgl_term_r <= 1'b0;
                tgl_echo_r <= 1'b0;
            end else if (rd_pend_r && accept) begin
                rd_down_r <= rd_down_r - 9'h001;
            end
            // Park a finished record for the next read
            if (!rd_pend_r && (ended || (host_cmd && !buf_full))) begin
                bp_valid_r <= 1'b1;
                bp_code_r <= ended ? code_nxt : rx_term_pkg::TC_HOST;
                bp_len_r <= ended ? rec_len_r + 9'(store_nxt) : rec_len_r;
            end
        end
    end

    // Data-available event for alert mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_sent_r <= 1'b0;
            data_avail_evt <= 1'b0;
        end else begin
            data_avail_evt <= 1'b0;
            if (!cfg_r[rx_term_pkg::CFG_ALERT] || !rec_active) begin
                alert_sent_r <= 1'b0;
            end
            if (cfg_r[rx_term_pkg::CFG_ALERT] && !rd_pend_r &&
                !alert_sent_r && rec_active && !bp_valid_r) begin
                data_avail_evt <= 1'b1;
                alert_sent_r <= 1'b1;
            end
        end
    end

    // Echo queue: push non-terminators, CR/LF pair for selected one
    logic echo_push, crlf_push, lf_pend_r;
    assign echo_push = accept && echo_on && !is_term;
    assign crlf_push = accept && echo_on && is_term &&
        cfg_r[rx_term_pkg::CFG_CRLF] && rx_char == echo_sel_r;

    always_ff @(posedge pclk) begin
        if ((echo_push || crlf_push || lf_pend_r) &&
            echo_cnt_r != rx_term_pkg::ECHO_DEPTH) begin
            echo_mem[echo_wp_r] <= echo_push ? rx_char :
                (crlf_push ? rx_term_pkg::CR_CHAR : rx_term_pkg::LF_CHAR);
        end
    end

    logic pop_ok, push_ok;
    assign pop_ok = echo_pop && echo_valid;
    assign push_ok = (echo_push || crlf_push || lf_pend_r) &&
                     echo_cnt_r != rx_term_pkg::ECHO_DEPTH;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            echo_wp_r <= 7'h00;
            echo_rp_r <= 7'h00;
            echo_cnt_r <= 9'h000;
            lf_pend_r <= 1'b0;
            echo_valid <= 1'b0;
            echo_char <= 8'h00;
        end else begin
            lf_pend_r <= crlf_push;
            if (push_ok) begin
                echo_wp_r <= echo_wp_r + 7'h01;
            end
            if (pop_ok) begin
                echo_rp_r <= echo_rp_r + 7'h01;
            end
            echo_cnt_r <= echo_cnt_r + 9'(push_ok) - 9'(pop_ok);
            // Hold echoes behind an active transmit record
            echo_valid <= !tx_record_active && !pop_ok &&
                          echo_cnt_r != 9'h000;
            echo_char <= echo_mem[echo_rp_r];
        end
    end

    // APB slave: zero wait, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b1;
            pslverr <= 1'b0;
            stat_evt_r <= 8'h00;
        end else begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= paddr > rx_term_pkg::EVT_OFF || paddr[1:0] != 0;
            end
            if (ended || host_cmd) begin
                stat_evt_r <= {5'h00, ended ? code_nxt :
                               rx_term_pkg::TC_HOST};
            end
            if (bus_rd) begin
                if (paddr == rx_term_pkg::CFG_OFF) begin
                    prdata <= {24'h00_0000, cfg_r};
                end else if (paddr == rx_term_pkg::EOC_OFF) begin
                    prdata <= {24'h00_0000, eoc_r};
                end else if (paddr == rx_term_pkg::TERM0_OFF) begin
                    prdata <= term_r[31:0];
                end else if (paddr == rx_term_pkg::TERM1_OFF) begin
                    prdata <= term_r[63:32];
                end else if (paddr == rx_term_pkg::ECHOSEL_OFF) begin
                    prdata <= {24'h00_0000, echo_sel_r};
                end else if (paddr == rx_term_pkg::STAT_OFF) begin
                    prdata <= {15'h0000, rd_pend_r, last_term_r,
                               5'h00, last_code_r};
                end else if (paddr == rx_term_pkg::REC_OFF) begin
                    prdata <= {7'h00, done_len_r, 7'h00, rec_len_r};
                end else if (paddr == rx_term_pkg::EVT_OFF) begin
                    prdata <= {16'h0000, last_term_r, stat_evt_r};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Assertions
    property p_card_eoc;
        @(posedge pclk) disable iff (!presetn)
        accept && !rx_error && !is_term && rec_len_r == 9'h0FB &&
        !(rd_pend_r && rd_down_r == 9'h001) &&
        !(cfg_r[2] && eoc_cnt_r == 8'h01) |=> rec_len_r == 9'h000;
    endproperty
    a_card_eoc: assert property (p_card_eoc)
        else $error("record not cut at 252");
    property p_term_code;
        @(posedge pclk) disable iff (!presetn)
        accept && is_term && !rx_error |=> last_code_r == 3'b001;
    endproperty
    a_term_code: assert property (p_term_code)
        else $error("terminator did not end record");
    property p_alert_zero;
        @(posedge pclk) disable iff (!presetn)
        read_cmd && !rd_pend_r && cfg_r[3] && !rec_active &&
        !bp_valid_r |=> read_done && read_len == 9'h000;
    endproperty
    a_alert_zero: assert property (p_alert_zero)
        else $error("alert empty read not zero length");
    property p_no_term_echo;
        @(posedge pclk) disable iff (!presetn)
        is_term |-> !echo_push;
    endproperty
    a_no_term_echo: assert property (p_no_term_echo)
        else $error("terminator echoed");
    property p_full_drop;
        @(posedge pclk) disable iff (!presetn)
        rx_valid && buf_full |-> !echo_push ##1 $stable(wr_ptr_r);
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("char taken while full");
    property p_echo_hold;
        @(posedge pclk) disable iff (!presetn)
        tx_record_active |=> !echo_valid;
    endproperty
    a_echo_hold: assert property (p_echo_hold)
        else $error("echo during transmit record");
    property p_echo_cap;
        @(posedge pclk) disable iff (!presetn)
        echo_cnt_r <= 9'h080;
    endproperty
    a_echo_cap: assert property (p_echo_cap)
        else $error("echo buffer over 128");
    property p_stage;
        @(posedge pclk) disable iff (!presetn)
        rec_active && !ended |=> $stable(cfg_r);
    endproperty
    a_stage: assert property (p_stage)
        else $error("config changed mid record");
    c_alert: cover property (@(posedge pclk) data_avail_evt);
    c_read: cover property (@(posedge pclk) read_done && read_code == 3'b100);
    c_host: cover property (@(posedge pclk) host_cmd && rec_active);
endmodule
